// [mua_pkg.sv]
// constants and types for the management user access block
package mua_pkg;

   // slots, widths
   localparam int unsigned N_SLOTS       = 2;
   localparam int unsigned ADDR_W        = 5;

   // register byte offsets
   localparam logic [4:0]  OFS_CTRL      = 5'h00;
   localparam logic [4:0]  OFS_RAW       = 5'h04;
   localparam logic [4:0]  OFS_MASKED    = 5'h08;
   localparam logic [4:0]  OFS_MSET      = 5'h0C;
   localparam logic [4:0]  OFS_MCLR      = 5'h10;
   localparam logic [4:0]  OFS_SLOT0     = 5'h14;
   localparam logic [4:0]  OFS_STRIDE    = 5'h04;

   // access slot fields
   localparam int unsigned GO_BIT        = 31;
   localparam int unsigned DIR_BIT       = 30;
   localparam int unsigned ACK_BIT       = 29;
   localparam int unsigned REG_HI        = 25;
   localparam int unsigned REG_LO        = 21;
   localparam int unsigned PHY_HI        = 20;
   localparam int unsigned PHY_LO        = 16;
   localparam int unsigned DATA_HI       = 15;
   localparam logic [31:0] RESV_MASK     = 32'h1C00_0000;

   // control register fields
   localparam int unsigned CTRL_EN_BIT   = 0;
   localparam int unsigned CTRL_BUSY_BIT = 1;

   // reset values
   localparam logic [31:0] SLOT_RST      = 32'h0000_0000;
   localparam logic [1:0]  MASK_RST      = 2'h0;
   localparam logic [1:0]  RAW_RST       = 2'h0;
   localparam logic        EN_RST        = 1'b0;

   // serial frame layout, bit indices in send order
   localparam logic [31:0] PREAMBLE      = 32'hFFFF_FFFF;
   localparam logic [1:0]  START_CODE    = 2'h1;
   localparam logic [1:0]  OP_WR         = 2'h1;
   localparam logic [1:0]  OP_RD         = 2'h2;
   localparam logic [1:0]  TA_WR         = 2'h2;
   localparam logic [1:0]  TA_RD         = 2'h3;
   localparam logic [5:0]  TA1_IDX       = 6'h2E;
   localparam logic [5:0]  TA2_IDX       = 6'h2F;
   localparam logic [5:0]  DATA0_IDX     = 6'h30;
   localparam logic [5:0]  LAST_IDX      = 6'h3F;

   typedef enum logic {MUA_IDLE, MUA_RUN} mua_state_t;

endpackage : mua_pkg

// [mua_top.sv]
// management user access slots, completion interrupts and serial engine
`timescale 1ns/1ns

// What this block does
// - masked bit is completion and mask both set
// - write 1 clears masked bit, 0 ignored
// - mask set write 1 enables slot interrupt
// - mask 0 keeps slot interrupt low
// - mask clear write 1 disables slot interrupt
// - launch bit starts transfer when engine free
// - launch write ignored while engine disabled
// - launch bit self clears at completion
// - slot writes blocked while launch bit set
// - direction bit selects write or read
// - acknowledge bit set when phy acknowledges read
// - bits 25-21 select phy register
// - bits 20-16 select target phy
// - data written, or loaded from read
// - bits 28-26 reserved, read zero
// - raw completion bit set, write 1 or read of raw register clears
module mua_top #(
   parameter int unsigned N_SLOTS = mua_pkg::N_SLOTS
) (
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        ce,
   input  wire logic [4:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        mdc,
   input  wire logic        mdio_i,
   output logic             mdio_o,
   output logic             mdio_oe,
   output logic             irq
);

   // bus slave state
   logic                wait_q;
   logic [31:0]         rdata_q;
   logic                irq_q;
   logic                en_q;
   logic [N_SLOTS-1:0]  raw_q;
   logic [N_SLOTS-1:0]  raw_d;
   logic [N_SLOTS-1:0]  mask_q;
   logic [N_SLOTS-1:0]  mask_d;
   logic [31:0]         slot_q [N_SLOTS];
   logic [31:0]         slot_d [N_SLOTS];

   // link synchronisers and engine state
   logic                mdc_s1_q;
   logic                mdc_s2_q;
   logic                mdc_s3_q;
   logic                mdi_s1_q;
   logic                mdi_s2_q;
   mua_pkg::mua_state_t state_q;
   logic [5:0]          cnt_q;
   logic [63:0]         sh_q;
   logic                cur_q;
   logic                mdo_q;
   logic                oe_q;
   logic                done_q;
   logic                ack_q;
   logic [15:0]         rx_q;

   // bus decode
   wire                 req        = avs_read | avs_write;
   wire                 acc        = ce & req & ~wait_q;
   wire                 acc_wr     = acc & avs_write;
   wire                 acc_rd     = acc & avs_read;
   wire                 hit_ctrl   = avs_address == mua_pkg::OFS_CTRL;
   wire                 hit_raw    = avs_address == mua_pkg::OFS_RAW;
   wire                 hit_masked = avs_address == mua_pkg::OFS_MASKED;
   wire                 hit_mset   = avs_address == mua_pkg::OFS_MSET;
   wire                 hit_mclr   = avs_address == mua_pkg::OFS_MCLR;
   wire [31:0]          wmask      = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                                      {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   wire [31:0]          wd         = avs_writedata & wmask;
   logic [N_SLOTS-1:0]  hit_slot;
   logic [N_SLOTS-1:0]  done_vec;
   logic [N_SLOTS-1:0]  go_vec;

   // per-slot decode
   genvar gi;
   generate
      for (gi = 0; gi < N_SLOTS; gi++) begin : g_slot
         assign hit_slot[gi] = avs_address == 5'(mua_pkg::OFS_SLOT0 + mua_pkg::OFS_STRIDE * gi);
         assign done_vec[gi] = done_q & (cur_q == 1'(gi));
         assign go_vec[gi]   = slot_q[gi][mua_pkg::GO_BIT];
      end
   endgenerate

   // interrupt bits
   wire [N_SLOTS-1:0]   masked_w   = raw_q & mask_q;
   wire [N_SLOTS-1:0]   w1c_raw    = (acc_wr & (hit_raw | hit_masked)) ? wd[N_SLOTS-1:0] : '0;
   wire [N_SLOTS-1:0]   rc_raw     = (acc_rd & hit_raw) ? '1 : '0;
   wire [N_SLOTS-1:0]   mset_w     = (acc_wr & hit_mset) ? wd[N_SLOTS-1:0] : '0;
   wire [N_SLOTS-1:0]   mclr_w     = (acc_wr & hit_mclr) ? wd[N_SLOTS-1:0] : '0;
   assign raw_d  = (raw_q & ~(w1c_raw | rc_raw)) | done_vec;
   assign mask_d = (mask_q | mset_w) & ~mclr_w;

   // engine selection, slot 0 first
   wire                 any_go     = |go_vec;
   wire                 sel        = ~go_vec[0];
   wire [31:0]          sel_slot   = slot_q[sel];
   wire                 sel_wr     = sel_slot[mua_pkg::DIR_BIT];
   wire                 cur_wr     = slot_q[cur_q][mua_pkg::DIR_BIT];
   wire                 mdc_rise   = mdc_s2_q & ~mdc_s3_q;
   wire                 mdc_fall   = ~mdc_s2_q & mdc_s3_q;
   wire [5:0]           cnt_nx     = 6'(cnt_q + 6'h01);
   wire [63:0]          frame      = {mua_pkg::PREAMBLE, mua_pkg::START_CODE,
                                      sel_wr ? mua_pkg::OP_WR : mua_pkg::OP_RD,
                                      sel_slot[mua_pkg::PHY_HI:mua_pkg::PHY_LO],
                                      sel_slot[mua_pkg::REG_HI:mua_pkg::REG_LO],
                                      sel_wr ? mua_pkg::TA_WR : mua_pkg::TA_RD,
                                      sel_wr ? sel_slot[mua_pkg::DATA_HI:0] : 16'hFFFF};

   // slot next values
   always_comb begin
      logic [31:0] mrg;
      mrg = '0;
      for (int i = 0; i < N_SLOTS; i++) begin
         slot_d[i] = slot_q[i];
         mrg = (slot_q[i] & ~wmask) | wd;
         if (acc_wr & hit_slot[i] & ~slot_q[i][mua_pkg::GO_BIT]) begin
            slot_d[i] = mrg & ~mua_pkg::RESV_MASK;
            slot_d[i][mua_pkg::GO_BIT] = en_q & wd[mua_pkg::GO_BIT];
         end
         if (done_vec[i]) begin
            slot_d[i][mua_pkg::GO_BIT] = 1'b0;
            if (!slot_q[i][mua_pkg::DIR_BIT]) begin
               slot_d[i][mua_pkg::ACK_BIT] = ack_q;
               slot_d[i][mua_pkg::DATA_HI:0] = rx_q;
            end
         end
      end
   end

   // read data selection
   logic [31:0] rmux;
   always_comb begin
      rmux = 32'h0000_0000;
      if (hit_ctrl) begin
         rmux[mua_pkg::CTRL_EN_BIT]   = en_q;
         rmux[mua_pkg::CTRL_BUSY_BIT] = state_q == mua_pkg::MUA_RUN;
      end
      if (hit_raw) rmux[N_SLOTS-1:0] = raw_q;
      if (hit_masked) rmux[N_SLOTS-1:0] = masked_w;
      if (hit_mset | hit_mclr) rmux[N_SLOTS-1:0] = mask_q;
      for (int i = 0; i < N_SLOTS; i++) begin
         if (hit_slot[i]) rmux = slot_q[i];
      end
   end

   // bus handshake, one wait cycle
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wait_q  <= 1'b1;
         rdata_q <= 32'h0000_0000;
      end else if (ce) begin
         wait_q <= ~(wait_q & req);
         if (wait_q & avs_read) rdata_q <= rmux;
      end
   end

   // control and interrupt registers
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         en_q   <= mua_pkg::EN_RST;
         raw_q  <= mua_pkg::RAW_RST;
         mask_q <= mua_pkg::MASK_RST;
         irq_q  <= 1'b0;
      end else if (ce) begin
         if (acc_wr & hit_ctrl & avs_byteenable[0]) en_q <= avs_writedata[mua_pkg::CTRL_EN_BIT];
         raw_q  <= raw_d;
         mask_q <= mask_d;
         irq_q  <= |(raw_d & mask_d);
      end
   end

   // access slots
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < N_SLOTS; i++) slot_q[i] <= mua_pkg::SLOT_RST;
      end else if (ce) begin
         for (int i = 0; i < N_SLOTS; i++) slot_q[i] <= slot_d[i];
      end
   end

   // link synchronisers
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mdc_s1_q <= 1'b1;
         mdc_s2_q <= 1'b1;
         mdc_s3_q <= 1'b1;
         mdi_s1_q <= 1'b1;
         mdi_s2_q <= 1'b1;
      end else if (ce) begin
         mdc_s1_q <= mdc;
         mdc_s2_q <= mdc_s1_q;
         mdc_s3_q <= mdc_s2_q;
         mdi_s1_q <= mdio_i;
         mdi_s2_q <= mdi_s1_q;
      end
   end

   // serial engine: drive on falling, sample on rising
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= mua_pkg::MUA_IDLE;
         cnt_q   <= 6'h00;
         sh_q    <= 64'h0;
         cur_q   <= 1'b0;
         mdo_q   <= 1'b1;
         oe_q    <= 1'b0;
         done_q  <= 1'b0;
         ack_q   <= 1'b0;
         rx_q    <= 16'h0000;
      end else if (ce) begin
         done_q <= 1'b0;
         case (state_q)
            mua_pkg::MUA_IDLE: begin
               if (en_q & any_go & mdc_fall) begin
                  cur_q   <= sel;
                  sh_q    <= {frame[62:0], 1'b0};
                  mdo_q   <= frame[63];
                  oe_q    <= 1'b1;
                  cnt_q   <= 6'h00;
                  ack_q   <= 1'b0;
                  state_q <= mua_pkg::MUA_RUN;
               end
            end
            mua_pkg::MUA_RUN: begin
               if (mdc_fall & (cnt_q != mua_pkg::LAST_IDX)) begin
                  cnt_q <= cnt_nx;
                  mdo_q <= sh_q[63];
                  sh_q  <= {sh_q[62:0], 1'b0};
                  oe_q  <= cur_wr | (cnt_nx < mua_pkg::TA1_IDX);
               end else if (mdc_rise) begin
                  if (!cur_wr & (cnt_q == mua_pkg::TA2_IDX)) ack_q <= ~mdi_s2_q;
                  if (!cur_wr & (cnt_q >= mua_pkg::DATA0_IDX)) rx_q <= {rx_q[14:0], mdi_s2_q};
                  if (cnt_q == mua_pkg::LAST_IDX) begin
                     done_q  <= 1'b1;
                     oe_q    <= 1'b0;
                     mdo_q   <= 1'b1;
                     state_q <= mua_pkg::MUA_IDLE;
                  end
               end
            end
            default: state_q <= mua_pkg::MUA_IDLE;
         endcase
      end
   end

   assign avs_readdata    = rdata_q;
   assign avs_waitrequest = wait_q;
   assign mdio_o          = mdo_q;
   assign mdio_oe         = oe_q;
   assign irq             = irq_q;

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   wire s0_wr_acc = acc_wr & hit_slot[0];
   wire s0_go     = slot_q[0][mua_pkg::GO_BIT];
   wire s1_wr_acc = acc_wr & hit_slot[1];
   wire s1_go     = slot_q[1][mua_pkg::GO_BIT];
   wire unmapped  = ~(hit_ctrl | hit_raw | hit_masked | hit_mset | hit_mclr | (|hit_slot));

   // detected falling edges inside a frame, for the bit count check
   logic [6:0] fall_cnt_q;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         fall_cnt_q <= 7'h00;
      end else if (ce) begin
         if (state_q == mua_pkg::MUA_IDLE) fall_cnt_q <= 7'h00;
         else if (mdc_fall) fall_cnt_q <= 7'(fall_cnt_q + 7'h01);
      end
   end

   irq_masked_a: assert property ($past(ce) |-> irq_q == |(raw_q & mask_q))
      else $error("interrupt output disagrees with masked bits");
   masked_clr_a: assert property (acc_wr & hit_masked & wd[0] & ~done_vec[0] |=> !raw_q[0])
      else $error("write one to masked bit did not clear it");
   mask_set_a: assert property (acc_wr & hit_mset & wd[0] |=> mask_q[0])
      else $error("mask set write did not enable slot");
   mask_clr_a: assert property (acc_wr & hit_mclr & wd[0] |=> !mask_q[0])
      else $error("mask clear write did not disable slot");
   mask_off_a: assert property (!mask_q[1] & $past(ce) & !mask_q[0] |-> !irq_q)
      else $error("interrupt raised with all masks off");
   slot_lock_a: assert property (s0_wr_acc & s0_go & ~done_vec[0] |=> $stable(slot_q[0]))
      else $error("slot changed by write while launched");
   go_gate_a: assert property (s0_wr_acc & ~s0_go & ~en_q |=> !s0_go)
      else $error("launch accepted while engine disabled");
   go_set_a: assert property (s0_wr_acc & ~s0_go & en_q & wd[mua_pkg::GO_BIT] |=> s0_go)
      else $error("launch write not taken");
   go_done_a: assert property (ce & done_vec[0] |=> !s0_go && raw_q[0])
      else $error("completion did not clear launch or set raw");
   resv_zero_a: assert property (slot_q[0][28:26] == 3'h0 && slot_q[1][28:26] == 3'h0)
      else $error("reserved slot bits not zero");
   read_turn_a: assert property (state_q == mua_pkg::MUA_RUN && !cur_wr && cnt_q >= mua_pkg::TA1_IDX
                                 |-> !oe_q)
      else $error("line driven during read turnaround or data");
   wait_one_a: assert property (ce & !wait_q |=> wait_q)
      else $error("waitrequest low longer than one cycle");

   // slot one interrupt and lock checks
   masked_clr1_a: assert property (acc_wr & hit_masked & wd[1] & ~done_vec[1]
                                   |=> !raw_q[1])
      else $error("write one to masked bit one did not clear it");
   mask_set1_a: assert property (acc_wr & hit_mset & wd[1]
                                 |=> mask_q[1])
      else $error("mask set write did not enable slot one");
   mask_clr1_a: assert property (acc_wr & hit_mclr & wd[1]
                                 |=> !mask_q[1])
      else $error("mask clear write did not disable slot one");
   slot1_lock_a: assert property (s1_wr_acc & s1_go & ~done_vec[1]
                                  |=> $stable(slot_q[1]))
      else $error("slot one changed by write while launched");
   go_done1_a: assert property (ce & done_vec[1]
                                |=> !s1_go && raw_q[1])
      else $error("completion did not clear launch or set raw of slot one");

   // hold checks
   raw_hold_a: assert property (ce & !done_vec[0] & !(acc & (hit_raw | hit_masked))
                                |=> $stable(raw_q[0]))
      else $error("raw bit changed without event or access");
   mask_hold_a: assert property (ce & !(acc_wr & (hit_mset | hit_mclr))
                                 |=> $stable(mask_q))
      else $error("mask changed without mask write");
   go_zero_a: assert property (s0_wr_acc & ~s0_go & ~wd[mua_pkg::GO_BIT]
                               |=> !s0_go)
      else $error("launch set by a zero write");
   idle_gate_a: assert property (ce & !en_q & state_q == mua_pkg::MUA_IDLE
                                 |=> state_q == mua_pkg::MUA_IDLE)
      else $error("engine started while disabled");

   // link checks
   idle_line_a: assert property (state_q == mua_pkg::MUA_IDLE
                                 |-> !oe_q && mdo_q)
      else $error("line driven while engine idle");
   wr_drive_a: assert property (state_q == mua_pkg::MUA_RUN && cur_wr
                                |-> oe_q)
      else $error("line released during write frame");
   done_pulse_a: assert property (done_q
                                  |=> !done_q)
      else $error("completion pulse longer than one cycle");
   frame_bits_a: assert property (done_q
                                  |-> fall_cnt_q == 7'h3F && state_q == mua_pkg::MUA_IDLE)
      else $error("frame ended after wrong bit count");

   // read data checks
   masked_rd_a: assert property (ce & wait_q & avs_read & hit_masked
                                 |=> rdata_q[N_SLOTS-1:0] == $past(masked_w))
      else $error("masked read data wrong");
   unmapped_rd_a: assert property (ce & wait_q & avs_read & unmapped
                                   |=> rdata_q == 32'h0000_0000)
      else $error("unmapped read not zero");
   slot_rd_a: assert property (ce & wait_q & avs_read & hit_slot[0]
                               |=> rdata_q == $past(slot_q[0]))
      else $error("slot read data wrong");
   wait_ans_a: assert property (ce & wait_q & req
                                |=> !wait_q)
      else $error("request not answered after one wait cycle");

   rd_done_c: cover property (done_q & !cur_wr);
   wr_done_c: cover property (done_q & cur_wr);
   irq_rise_c: cover property (!irq_q ##1 irq_q);
   lock_c: cover property (s0_wr_acc & s0_go);
   gated_c: cover property (s0_wr_acc & ~en_q);

endmodule : mua_top

// [mua_phy_model.sv]
// management phy model answering clause 22 frames
`timescale 1ns/1ns
module mua_phy_model #(
   parameter logic [4:0] PHY_ID = 5'h03
) (
   input  wire logic run,
   input  wire logic dev_o,
   input  wire logic dev_oe,
   output logic      mdc,
   output logic      line
);
   logic [15:0] mem [32];
   logic        phy_oe;
   logic        phy_o;
   logic        in_frame;
   logic [5:0]  idx;
   logic [5:0]  ones;
   logic [11:0] hdr;
   logic [15:0] wd;
   // pull-up holds the line high when released
   assign line = dev_oe ? dev_o : (phy_oe ? phy_o : 1'b1);
   initial begin
      foreach (mem[i]) mem[i] = 16'h0000;
      {phy_oe, phy_o, in_frame, idx, ones, hdr, wd} = '0;
      mdc = 1'b1;
      #3;
      forever #80 if (run || !mdc) mdc = ~mdc;  // stands high between frames
   end
   always @(posedge mdc) begin
      if (!in_frame) begin
         ones <= (line === 1'b1) ? ((ones == 6'h3F) ? ones : ones + 6'h01) : 6'h00;
         if (ones >= 6'h20 && line === 1'b0) begin
            in_frame <= 1'b1;
            idx <= 6'h20;
            ones <= 6'h00;
         end
      end else begin
         idx <= idx + 6'h01;
         wd <= {wd[14:0], line};
         if (idx < 6'h2D) hdr <= {hdr[10:0], line};
         if (idx == 6'h3E) begin
            in_frame <= 1'b0;
            if (hdr[11:10] == 2'h1 && hdr[9:5] == PHY_ID) mem[hdr[4:0]] <= {wd[14:0], line};
         end
      end
   end
   always @(negedge mdc) begin
      phy_oe <= in_frame && hdr[9:5] == PHY_ID && hdr[11:10] == 2'h2 && idx >= 6'h2E;
      phy_o  <= (idx == 6'h2E) ? 1'b0 : mem[hdr[4:0]][6'h3E - idx];
   end
endmodule : mua_phy_model

// [testbench.sv]
// self-checking bench of the user access block
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin error_cnt++; \
   $display("Error %s expected %h seen %h", nm, exp, got); end end
module testbench;
   logic        clk;
   logic        rst_b;
   logic [4:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        mdc;
   logic        line;
   logic        mdio_o;
   logic        mdio_oe;
   logic        irq;
   logic        run;
   int          error_cnt;
   int          comparisons;
   localparam logic [4:0] SLOT1 = mua_pkg::OFS_SLOT0 + mua_pkg::OFS_STRIDE;
   mua_top u_dut (.clk(clk), .rst_b(rst_b), .ce(1'b1), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .mdc(mdc), .mdio_i(line), .mdio_o(mdio_o), .mdio_oe(mdio_oe), .irq(irq));
   mua_phy_model u_phy (.run(run), .dev_o(mdio_o), .dev_oe(mdio_oe), .mdc(mdc), .line(line));
   always #5 clk = ~clk;
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= ~w;
      avs_writedata <= d;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      if (n >= 20) error_cnt++;
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr
   task automatic chk_rd(input string nm, input logic [4:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0000_0000, q);
      `CHK(nm, exp, q)
   endtask : chk_rd
   task automatic wait_done(input logic [4:0] a, output logic [31:0] q);
      int n;
      run = 1'b1;
      for (n = 0; n < 600; n++) begin
         bus(1'b0, a, 32'h0000_0000, q);
         if (q[31] === 1'b0) break;
      end
      if (n >= 600) error_cnt++;
      run = 1'b0;
      repeat (3) @(posedge clk);
   endtask : wait_done
   task automatic t_reset;
      chk_rd("slot0", mua_pkg::OFS_SLOT0, 32'h0000_0000);
      chk_rd("mask", mua_pkg::OFS_MSET, 32'h0000_0000);
      chk_rd("masked", mua_pkg::OFS_MASKED, 32'h0000_0000);
      chk_rd("unmapped", 5'h1C, 32'h0000_0000);
      `CHK("irq", 1'b0, irq)
   endtask : t_reset
   task automatic t_disabled;
      wr(mua_pkg::OFS_SLOT0, 32'hFFFF_FFFF);
      chk_rd("slot0", mua_pkg::OFS_SLOT0, 32'h63FF_FFFF);
   endtask : t_disabled
   task automatic t_write;
      logic [31:0] q;
      wr(mua_pkg::OFS_CTRL, 32'h0000_0001);
      wr(mua_pkg::OFS_MSET, 32'h0000_0001);
      wr(mua_pkg::OFS_SLOT0, 32'hC0A3_A5C3);
      wr(mua_pkg::OFS_SLOT0, 32'h0000_1111);
      chk_rd("slot0", mua_pkg::OFS_SLOT0, 32'hC0A3_A5C3);
      wait_done(mua_pkg::OFS_SLOT0, q);
      `CHK("slot0", 32'h40A3_A5C3, q)
      `CHK("phy reg", 16'hA5C3, u_phy.mem[5])
      `CHK("irq", 1'b1, irq)
      chk_rd("masked", mua_pkg::OFS_MASKED, 32'h0000_0001);
      wr(mua_pkg::OFS_MASKED, 32'h0000_0000);
      chk_rd("masked", mua_pkg::OFS_MASKED, 32'h0000_0001);
      wr(mua_pkg::OFS_MASKED, 32'h0000_0001);
      chk_rd("masked", mua_pkg::OFS_MASKED, 32'h0000_0000);
      `CHK("irq", 1'b0, irq)
   endtask : t_write
   task automatic t_read;
      logic [31:0] q;
      wr(SLOT1, 32'h80A3_0000);
      wait_done(SLOT1, q);
      `CHK("slot1", 32'h20A3_A5C3, q)
      `CHK("irq", 1'b0, irq)
      chk_rd("masked", mua_pkg::OFS_MASKED, 32'h0000_0000);
      chk_rd("raw", mua_pkg::OFS_RAW, 32'h0000_0002);
   endtask : t_read
   task automatic t_noack;
      logic [31:0] q;
      wr(mua_pkg::OFS_MCLR, 32'h0000_0000);
      chk_rd("mask", mua_pkg::OFS_MSET, 32'h0000_0001);
      wr(mua_pkg::OFS_MCLR, 32'h0000_0001);
      chk_rd("mask", mua_pkg::OFS_MSET, 32'h0000_0000);
      wr(mua_pkg::OFS_SLOT0, 32'h80A7_0000);
      wait_done(mua_pkg::OFS_SLOT0, q);
      `CHK("slot0", 32'h00A7_FFFF, q)
      `CHK("irq", 1'b0, irq)
      wr(mua_pkg::OFS_RAW, 32'h0000_0001);
      chk_rd("raw", mua_pkg::OFS_RAW, 32'h0000_0000);
   endtask : t_noack
   task automatic end_of_test;
      $display("checks %0d errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : end_of_test
   initial begin
      #300000;
      error_cnt++;
      end_of_test();
   end
   initial begin
      {clk, rst_b, avs_read, avs_write, run} = '0;
      avs_address = 5'h00;
      avs_writedata = 32'h0000_0000;
      error_cnt = 0;
      comparisons = 0;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      t_reset();
      t_disabled();
      t_write();
      t_read();
      t_noack();
      end_of_test();
   end
endmodule : testbench
